// File: hdl/vid_timing_pkg.sv
// Summary of operation
// - load three colour serialisers, shift out streams
// - sequencer: one load then seven shifts
// - three-flop modified LFSR holds sequencer state
// - each dot advances line timing
// - load rising edge increments column address
// - serialisers load 400 ns after load edge
// - delayed load lags load by three dots
// - delayed load edge 150 ns after load
// - next load 250 ns after delayed load
// - column address cleared when line blanking starts
// - line sync and blanking from column timing
// - line period 64.5 us, 2 us porches
// - blank rising edge increments font row
// - blank also advances character line address
// - retrace status shows line or frame blanking
// - frame sync output active low and high
// - frame sync starts on line sync, twelve lines
// - counters cleared, frame resumes after thirteen syncs
// - 128 characters per line, 24 lines
// - character cell twelve lines by eight dots
// - 288 visible lines from 20 MHz dots
// - line rate 15.5 kHz, frame about 51.7 Hz
// - serialiser captures when load phase high, else shifts
// - video blank forces all serial outputs low
// - load flag registered from all-zero sequencer
package vid_timing_pkg;

  // dot clock and derived period
  localparam int DOT_CLK_HZ       = 20000000;                 // dot clock rate
  localparam int DOT_NS           = 1000000000 / DOT_CLK_HZ;  // 50 ns per dot
  localparam int CHAR_DOTS        = 8;                        // dots per character cell
  // character cycle timing
  localparam int CHAR_LOAD_NS     = 400;                      // load edge to serialiser load
  localparam int LOAD_TO_DLOAD_NS = 150;                      // load edge to delayed load edge
  localparam int DLOAD_TO_LOAD_NS = 250;                      // delayed load edge to next load
  localparam int DLOAD_CYCLES     = LOAD_TO_DLOAD_NS / DOT_NS;  // 3 dots
  // line timing
  localparam int LINE_PERIOD_NS   = 64500;                    // line sync period
  localparam int PORCH_NS         = 2000;                     // front and back porch
  localparam int LINE_DOTS        = LINE_PERIOD_NS / DOT_NS;  // 1290 dots per line
  localparam int PORCH_DOTS       = PORCH_NS / DOT_NS;        // 40 dots
  // display format
  localparam int VISIBLE_CHARS    = 128;                      // characters per line
  localparam int CHAR_LINES       = 24;                       // character lines per frame
  localparam int FONT_ROWS        = 12;                       // scan lines per character
  localparam int FSYNC_LINES      = 12;                       // frame sync length in lines
  // address widths
  localparam int COL_W            = 7;                        // column address bits
  localparam int CLINE_W          = 5;                        // character line address bits
  localparam int ROW_W            = 4;                        // font row address bits
  localparam int H_W              = 11;                       // dot counter bits
  localparam int FIFO_DEPTH       = 8;                        // words in dot fifo
  // sequencer
  localparam logic [2:0] SEQ_RESET   = 3'h0;                  // all-zero load state
  localparam logic [2:0] SEQ_PRELOAD = 3'h4;                  // state before all-zero

  // frame state: active, waiting for sync, frame sync
  typedef enum logic [1:0] {
    V_ACTIVE = 2'h0,
    V_WAIT   = 2'h1,
    V_SYNC   = 2'h3
  } vstate_t;

endpackage

// File: hdl/char_video_timing_controller.sv
`timescale 1ns/10ps
`default_nettype none

////////////////////////////////////////////////////////////////////////////////
// small synchronous fifo between font data and serialisers
module dot_fifo #(
  parameter int WIDTH = 24,
  parameter int DEPTH = 8
) (
  input  wire logic             clk,       // dot clock
  input  wire logic             reset_n,   // synchronous reset, active low
  input  wire logic             in_valid,  // write request
  output logic                  in_ready,  // room for a word
  input  wire logic [WIDTH-1:0] in_data,   // word written
  output logic                  out_valid, // a word is held
  input  wire logic             out_ready, // read request
  output logic      [WIDTH-1:0] out_data   // oldest word
);
  localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;   // pointer width

  logic [WIDTH-1:0] mem [DEPTH];   // storage array
  logic [PW-1:0]    wr_ptr_reg;    // write index
  logic [PW-1:0]    rd_ptr_reg;    // read index
  logic [PW:0]      count_reg;     // words held
  logic             do_push;       // accepted write
  logic             do_pop;        // accepted read

  // pointer advance with wrap at depth
  function automatic logic [PW-1:0] next_ptr(input logic [PW-1:0] p);
    next_ptr = (p == PW'(DEPTH - 1)) ? '0 : PW'(p + 1'b1);
  endfunction

  assign in_ready  = (count_reg != (PW+1)'(DEPTH));
  assign out_valid = (count_reg != '0);
  assign do_push   = in_valid && in_ready;
  assign do_pop    = out_valid && out_ready;
  assign out_data  = mem[rd_ptr_reg];

  // storage write, no reset needed on data
  always_ff @(posedge clk) begin
    if (do_push) begin
      mem[wr_ptr_reg] <= in_data;
    end
  end

  // pointers and fill count
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
      count_reg  <= '0;
    end else begin
      if (do_push) begin
        wr_ptr_reg <= next_ptr(wr_ptr_reg);
      end
      if (do_pop) begin
        rd_ptr_reg <= next_ptr(rd_ptr_reg);
      end
      count_reg <= (PW+1)'(count_reg + {PW'(0), do_push} - {PW'(0), do_pop});
    end
  end
endmodule

////////////////////////////////////////////////////////////////////////////////
// character-mode video timing controller
module char_video_timing_controller #(
  parameter int VISIBLE_CHARS = vid_timing_pkg::VISIBLE_CHARS,
  parameter int CHAR_LINES    = vid_timing_pkg::CHAR_LINES,
  parameter int FONT_ROWS     = vid_timing_pkg::FONT_ROWS,
  parameter int FIFO_DEPTH    = vid_timing_pkg::FIFO_DEPTH
) (
  input  wire logic        CLK,             // 20 MHz dot clock
  input  wire logic        RESET_N,         // synchronous reset, active low
  input  wire logic [7:0]  RED_DOTS_IN,     // red font dots
  input  wire logic [7:0]  GREEN_DOTS_IN,   // green font dots
  input  wire logic [7:0]  BLUE_DOTS_IN,    // blue font dots
  output logic             DOTS_READY,      // dot fifo has room
  output logic [11:0]      VIDEO_RAM_ADDR,  // character line and column
  output logic [3:0]       FONT_ROW_ADDR,   // row within font cell
  output logic             LOAD_FLAG,       // parallel load pulse
  output logic             DELAYED_LOAD,    // clocks external octal register
  output logic             RED_OUT,         // red serial dots
  output logic             GREEN_OUT,       // green serial dots
  output logic             BLUE_OUT,        // blue serial dots
  output logic             LINE_SYNC,       // horizontal sync, active high
  output logic             LINE_BLANK,      // horizontal blanking, active high
  output logic             FRAME_SYNC_N,    // frame sync, active low
  output logic             FRAME_SYNC,      // frame sync, active high
  output logic             RETRACE          // line or frame blanking status
);
  localparam int COL_W   = vid_timing_pkg::COL_W;
  localparam int CLINE_W = vid_timing_pkg::CLINE_W;
  localparam int ROW_W   = vid_timing_pkg::ROW_W;
  localparam int H_W     = vid_timing_pkg::H_W;
  // horizontal decode points
  localparam logic [H_W-1:0] H_LAST       = H_W'(vid_timing_pkg::LINE_DOTS - 1);
  localparam logic [H_W-1:0] H_ACT_LAST   =
    H_W'(VISIBLE_CHARS * vid_timing_pkg::CHAR_DOTS - 1);
  localparam logic [H_W-1:0] H_SYNC_PRE   =
    H_W'(VISIBLE_CHARS * vid_timing_pkg::CHAR_DOTS + vid_timing_pkg::PORCH_DOTS - 1);
  localparam logic [H_W-1:0] H_SYNC_LAST  =
    H_W'(vid_timing_pkg::LINE_DOTS - vid_timing_pkg::PORCH_DOTS - 1);
  localparam logic [ROW_W-1:0]   ROW_LAST   = ROW_W'(FONT_ROWS - 1);
  localparam logic [CLINE_W-1:0] CLINE_LAST = CLINE_W'(CHAR_LINES - 1);
  localparam logic [ROW_W-1:0]   FS_LINES   = ROW_W'(vid_timing_pkg::FSYNC_LINES);

  //////////////////////////////////////////////////////////////////////////////
  // declarations
  logic                  seq_bit_a;         // sequencer bit, oldest
  logic                  seq_bit_b;         // sequencer bit, middle
  logic                  seq_bit_c;         // sequencer bit, newest
  logic [2:0]            seq_reg;           // {a,b,c}
  logic [2:0]            seq_next;          // next sequencer state
  logic                  seq_fb;            // feedback bit
  logic                  load_flag_reg;     // registered load control
  logic                  load_phase;        // serialiser capture enable
  logic [2:0]            dly_reg;           // delayed load shift register
  logic [H_W-1:0]        h_dot_reg;         // dot position in line
  logic                  line_blank_reg;    // horizontal blanking
  logic                  line_sync_reg;     // horizontal sync
  logic                  end_of_active;     // blank about to rise
  logic                  sync_start;        // sync about to rise
  logic                  sync_end;          // sync about to fall
  logic                  end_of_line;       // dot counter wraps
  logic [COL_W-1:0]      column_addr_reg;   // low address bits
  logic [CLINE_W-1:0]    char_line_reg;     // high address bits
  logic [ROW_W-1:0]      font_row_reg;      // font row counter
  logic [ROW_W-1:0]      fs_count_reg;      // line syncs in frame sync
  vid_timing_pkg::vstate_t vstate_reg;      // frame state
  vid_timing_pkg::vstate_t vstate_next;     // next frame state
  logic                  frame_done;        // frame sync over
  logic                  frame_sync_reg;    // frame sync level
  logic                  video_blank;       // line or frame blanking
  logic                  retrace_reg;       // retrace status flop
  logic                  fifo_push;         // dot word offered
  logic                  fifo_ready;        // dot fifo has room
  logic                  fifo_valid;        // dot word held
  logic [23:0]           fifo_data;         // oldest dot word
  logic [7:0]            red_sh_reg;        // red serialiser
  logic [7:0]            green_sh_reg;      // green serialiser
  logic [7:0]            blue_sh_reg;       // blue serialiser
  logic                  red_out_reg;       // red output flop
  logic                  green_out_reg;     // green output flop
  logic                  blue_out_reg;      // blue output flop

  //////////////////////////////////////////////////////////////////////////////
  // character sequencer
  // modified lfsr feedback
  assign seq_reg    = {seq_bit_a, seq_bit_b, seq_bit_c};
  assign seq_fb     = seq_bit_a ^ seq_bit_b ^ (seq_bit_b == 1'b0 && seq_bit_c == 1'b0);
  assign seq_next   = {seq_bit_b, seq_bit_c, seq_fb};
  assign load_phase = load_flag_reg;

  always_ff @(posedge CLK) begin
    if (!RESET_N) begin
      {seq_bit_a, seq_bit_b, seq_bit_c} <= vid_timing_pkg::SEQ_RESET;
    end else begin
      {seq_bit_a, seq_bit_b, seq_bit_c} <= seq_next;
    end
  end

  // load flag and its three-dot delayed copy
  always_ff @(posedge CLK) begin
    if (!RESET_N) begin
      load_flag_reg <= 1'b0;
      dly_reg       <= 3'h0;
    end else begin
      load_flag_reg <= (seq_reg == vid_timing_pkg::SEQ_RESET);
      dly_reg       <= {dly_reg[1:0], load_flag_reg};
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // horizontal timing
  // decode points for blank and sync
  assign end_of_active = (h_dot_reg == H_ACT_LAST);
  assign sync_start    = (h_dot_reg == H_SYNC_PRE);
  assign sync_end      = (h_dot_reg == H_SYNC_LAST);
  assign end_of_line   = (h_dot_reg == H_LAST);

  // line blank and sync from line position
  always_ff @(posedge CLK) begin
    if (!RESET_N) begin
      h_dot_reg      <= '0;
      line_blank_reg <= 1'b0;
      line_sync_reg  <= 1'b0;
    end else begin
      h_dot_reg <= end_of_line ? '0 : H_W'(h_dot_reg + 1'b1);
      if (end_of_active) begin
        line_blank_reg <= 1'b1;
      end else if (end_of_line) begin
        line_blank_reg <= 1'b0;
      end
      if (sync_start) begin
        line_sync_reg <= 1'b1;
      end else if (sync_end) begin
        line_sync_reg <= 1'b0;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // column address
  always_ff @(posedge CLK) begin
    if (!RESET_N || frame_done) begin
      column_addr_reg <= '0;
    end else if (end_of_active) begin
      // next line starts at column zero
      column_addr_reg <= '0;
    end else if (load_flag_reg && !line_blank_reg) begin
      column_addr_reg <= COL_W'(column_addr_reg + 1'b1);
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // font row and character line, stepped by blank rising edge
  always_ff @(posedge CLK) begin
    if (!RESET_N || frame_done) begin
      font_row_reg  <= '0;
      char_line_reg <= '0;
    end else if (end_of_active && vstate_reg == vid_timing_pkg::V_ACTIVE) begin
      if (font_row_reg == ROW_LAST) begin
        font_row_reg  <= '0;
        char_line_reg <= CLINE_W'(char_line_reg + 1'b1);
      end else begin
        font_row_reg <= ROW_W'(font_row_reg + 1'b1);
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // frame state machine
  // frame sync ends on thirteenth line sync
  assign frame_done = (vstate_reg == vid_timing_pkg::V_SYNC) && sync_start &&
                      (fs_count_reg == FS_LINES);

  // next frame state
  always_comb begin
    vstate_next = vstate_reg;
    unique case (vstate_reg)
      vid_timing_pkg::V_ACTIVE: begin
        // leave after last visible character line
        if (end_of_active && font_row_reg == ROW_LAST && char_line_reg == CLINE_LAST) begin
          vstate_next = vid_timing_pkg::V_WAIT;
        end
      end
      vid_timing_pkg::V_WAIT: begin
        // sync begins with line sync rising
        if (sync_start) begin
          vstate_next = vid_timing_pkg::V_SYNC;
        end
      end
      vid_timing_pkg::V_SYNC: begin
        if (frame_done) begin
          vstate_next = vid_timing_pkg::V_ACTIVE;
        end
      end
      default: begin
        vstate_next = vid_timing_pkg::V_ACTIVE;
      end
    endcase
  end

  // frame state, sync length count and sync level
  always_ff @(posedge CLK) begin
    if (!RESET_N) begin
      vstate_reg     <= vid_timing_pkg::V_ACTIVE;
      fs_count_reg   <= '0;
      frame_sync_reg <= 1'b0;
    end else begin
      vstate_reg     <= vstate_next;
      frame_sync_reg <= (vstate_next == vid_timing_pkg::V_SYNC);
      if (vstate_next != vid_timing_pkg::V_SYNC) begin
        fs_count_reg <= '0;
      end else if (sync_start) begin
        fs_count_reg <= ROW_W'(fs_count_reg + 1'b1);
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // blanking and retrace status
  // line and frame blanking combined
  assign video_blank = line_blank_reg || (vstate_reg != vid_timing_pkg::V_ACTIVE);

  always_ff @(posedge CLK) begin
    if (!RESET_N) begin
      retrace_reg <= 1'b0;
    end else begin
      retrace_reg <= video_blank;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // dot fifo: font data taken just before each load
  assign fifo_push = (seq_reg == vid_timing_pkg::SEQ_PRELOAD);

  dot_fifo #(
    .WIDTH (24),
    .DEPTH (FIFO_DEPTH)
  ) u_dot_fifo (
    .clk       (CLK),
    .reset_n   (RESET_N),
    .in_valid  (fifo_push),
    .in_ready  (fifo_ready),
    .in_data   ({RED_DOTS_IN, GREEN_DOTS_IN, BLUE_DOTS_IN}),
    .out_valid (fifo_valid),
    .out_ready (load_phase),
    .out_data  (fifo_data)
  );

  //////////////////////////////////////////////////////////////////////////////
  // colour serialisers
  always_ff @(posedge CLK) begin
    if (!RESET_N) begin
      red_sh_reg   <= 8'h00;
      green_sh_reg <= 8'h00;
      blue_sh_reg  <= 8'h00;
    end else if (load_phase) begin
      // load one character cycle after the address edge
      // parallel load of all three colours
      red_sh_reg   <= fifo_valid ? fifo_data[23:16] : 8'h00;
      green_sh_reg <= fifo_valid ? fifo_data[15:8]  : 8'h00;
      blue_sh_reg  <= fifo_valid ? fifo_data[7:0]   : 8'h00;
    end else begin
      red_sh_reg   <= {red_sh_reg[6:0],   1'b0};
      green_sh_reg <= {green_sh_reg[6:0], 1'b0};
      blue_sh_reg  <= {blue_sh_reg[6:0],  1'b0};
    end
  end

  // serial output flops, forced low while blanked
  always_ff @(posedge CLK) begin
    if (!RESET_N) begin
      red_out_reg   <= 1'b0;
      green_out_reg <= 1'b0;
      blue_out_reg  <= 1'b0;
    end else begin
      red_out_reg   <= red_sh_reg[7]   && !video_blank;
      green_out_reg <= green_sh_reg[7] && !video_blank;
      blue_out_reg  <= blue_sh_reg[7]  && !video_blank;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // output wiring
  assign DOTS_READY     = fifo_ready;
  assign VIDEO_RAM_ADDR = {char_line_reg, column_addr_reg};
  assign FONT_ROW_ADDR  = font_row_reg;
  assign LOAD_FLAG      = load_flag_reg;
  assign DELAYED_LOAD   = dly_reg[2];
  assign RED_OUT        = red_out_reg;
  assign GREEN_OUT      = green_out_reg;
  assign BLUE_OUT       = blue_out_reg;
  assign LINE_SYNC      = line_sync_reg;
  assign LINE_BLANK     = line_blank_reg;
  assign FRAME_SYNC     = frame_sync_reg;
  assign FRAME_SYNC_N   = !frame_sync_reg;
  assign RETRACE        = retrace_reg;

  //////////////////////////////////////////////////////////////////////////////
  // checks
  default clocking cb @(posedge CLK); endclocking
  default disable iff (!RESET_N);

  chk_load_cycle: assert property (
    load_flag_reg |=> !load_flag_reg [*7] ##1 load_flag_reg)
    else $error("load pulse not once every eight dots");
  chk_load_zero: assert property (
    (seq_reg == 3'h0) |=> load_flag_reg)
    else $error("load flag missing after zero state");
  chk_delay_three: assert property (
    $rose(load_flag_reg) |-> !DELAYED_LOAD [*3] ##1 $rose(DELAYED_LOAD))
    else $error("delayed load not three dots after load");
  chk_dload_gap: assert property (
    $rose(DELAYED_LOAD) |-> ##5 $rose(load_flag_reg))
    else $error("next load not five dots after delayed load");
  chk_col_step: assert property (
    (load_flag_reg && !line_blank_reg && !end_of_active && !frame_done)
      |=> column_addr_reg == COL_W'($past(column_addr_reg) + 1'b1))
    else $error("column address did not advance on load");
  chk_col_clear: assert property (
    $rose(line_blank_reg) |-> column_addr_reg == '0)
    else $error("column address not cleared at line end");
  chk_porch_front: assert property (
    $rose(line_blank_reg) |-> ##40 $rose(line_sync_reg))
    else $error("front porch not 40 dots");
  chk_sync_in_blank: assert property (
    line_sync_reg |-> line_blank_reg)
    else $error("line sync outside blanking");
  chk_blank_dark: assert property (
    video_blank |=> !red_out_reg && !green_out_reg && !blue_out_reg)
    else $error("colour output active while blanked");
  chk_fsync_pair: assert property (
    FRAME_SYNC != FRAME_SYNC_N)
    else $error("frame sync outputs not complementary");
  chk_fsync_start: assert property (
    $rose(frame_sync_reg) |-> $rose(line_sync_reg))
    else $error("frame sync not started by line sync");
  chk_fsync_clear: assert property (
    $fell(frame_sync_reg) |-> VIDEO_RAM_ADDR == 12'h000 && font_row_reg == '0)
    else $error("addresses not cleared after frame sync");
  chk_retrace_flag: assert property (
    video_blank |=> retrace_reg)
    else $error("retrace status missed blanking");

  cov_frame_sync: cover property ($rose(frame_sync_reg));
  cov_row_wrap: cover property (font_row_reg == ROW_LAST ##1 font_row_reg == '0);
  cov_dots_out: cover property (red_out_reg && green_out_reg && blue_out_reg);
endmodule

`default_nettype wire

// File: test/font_mem_model.sv
`timescale 1ns/10ps
`default_nettype none
// font memory model: dots follow the fetched address a moment after each edge
module font_mem_model (
  input  wire logic        clk,   // dot clock
  input  wire logic [11:0] addr,  // character address
  input  wire logic [3:0]  row,   // font row
  input  wire logic [7:0]  key,   // pattern seed from the bench
  output logic      [7:0]  red,   // red dots
  output logic      [7:0]  green, // green dots
  output logic      [7:0]  blue   // blue dots
);
  initial {red, green, blue} = 24'h000000;
  // data settled well inside both windows
  always @(posedge clk) begin
    #1 red <= key ^ addr[7:0];
    green <= key ^ {row, addr[11:8]};
    blue <= ~key;
  end
endmodule
`default_nettype wire

// File: test/char_video_timing_controller_tb_top.sv
`timescale 1ns/10ps
`default_nettype none
module char_video_timing_controller_tb_top;
  logic clk = 1'b0, reset_n = 1'b0, lf, dl, ro, go, bo, ls, lb, fsn, fs, rt;
  logic [7:0] key = 8'h00, rd, gd, bd;
  logic [11:0] ra;
  logic [3:0] fr;
  logic p_lf, p_lb, p_ls, p_fs;
  logic [2:0] lf_h;
  logic [6:0] p_col;
  logic [23:0] m_sh, p_d1, p_d2;
  logic [2:0] e_bits;
  logic dr;
  int err_count = 0, total_checks = 0, cyc = 0, frames = 0;
  int gap, lsc, bkc, fsc, idx, nld;
  always #25 clk = ~clk;
  char_video_timing_controller #(.CHAR_LINES(2), .FONT_ROWS(2)) i_char_video_timing_controller (
    .CLK(clk), .RESET_N(reset_n), .RED_DOTS_IN(rd), .GREEN_DOTS_IN(gd), .BLUE_DOTS_IN(bd),
    .DOTS_READY(dr), .VIDEO_RAM_ADDR(ra), .FONT_ROW_ADDR(fr), .LOAD_FLAG(lf), .DELAYED_LOAD(dl),
    .RED_OUT(ro), .GREEN_OUT(go), .BLUE_OUT(bo), .LINE_SYNC(ls), .LINE_BLANK(lb),
    .FRAME_SYNC_N(fsn), .FRAME_SYNC(fs), .RETRACE(rt));
  font_mem_model i_font_mem_model (.clk(clk), .addr(ra), .row(fr), .key(key),
    .red(rd), .green(gd), .blue(bd));
  ////////////////////////////////////////////////////////////////////////////
  // compare and count
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] s);
    total_checks++;
    if (e !== s) begin
      err_count++;
      $display("wrong value %s expected %h seen %h", n, e, s);
    end
  endtask
  // verdict and end of run
  task automatic close_out;
    $display("checks %0d mismatches %0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  // outputs while reset is still held, just before its release
  task automatic reset_chk;
    chk("reset outputs", 0, {ra, fr, lf, dl, ro, go, bo, ls, lb, fs, rt, ~fsn});
  endtask
  // hang guard
  always @(posedge clk) begin
    cyc++;
    if (cyc == 60000) begin
      err_count++;
      close_out;
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  // timing monitor on sampled outputs
  always @(posedge clk) begin
    if (!reset_n) begin
      gap = -1000000; lsc = -1000000; bkc = -1000000; fsc = 0; idx = 0;
      {p_lf, p_lb, p_ls, p_fs, lf_h, p_col} = 0;
      {m_sh, p_d1, p_d2, e_bits} = 0;
      nld = 0;
    end else begin
      if (lf) begin
        if (gap > 0) chk("load gap", 8, gap);
        gap = 0;
      end
      gap++;
      chk("delayed load", lf_h[2], dl);
      lf_h = {lf_h[1:0], lf};
      chk("sync pair", !fs, fsn);
      if (idx < 4 && !p_fs) chk("retrace", p_lb, rt);
      if (p_lf && !p_lb && !lb) chk("column", 7'(p_col + 7'h01), ra[6:0]);
      if (lb && !p_lb) begin
        chk("column clear", 0, ra[6:0]);
        if (idx < 3) chk("font row", (idx + 1) % 2, fr);
        if (idx < 3) chk("char line", (idx + 1) / 2, ra[11:7]);
        idx++;
        bkc = 0;
      end
      if (ls && !p_ls) begin
        if (lsc > 0) chk("line period", 1290, lsc);
        if (bkc > 0) chk("front porch", 40, bkc);
        lsc = 0;
      end
      if (!ls && p_ls) chk("sync width", 186, lsc);
      if (!lb && p_lb && bkc > 0) chk("blank width", 266, bkc);
      if (fs && !p_fs) fsc = 0;
      if (!fs && p_fs) begin
        chk("frame sync length", 15480, fsc);
        chk("frame addr clear", 0, {fr, ra});
        idx = 0;
        frames++;
      end
      if ((lb && bkc > 3) || (fs && fsc > 3)) chk("blanked dots", 0, {ro, go, bo});
      // serialiser model: word fetched two edges before the load, msb first
      chk("dots ready", 1, dr);
      chk("serial dots", rt ? 3'h0 : e_bits, {ro, go, bo});
      e_bits = {m_sh[23], m_sh[15], m_sh[7]};
      if (lf) begin
        m_sh = (nld == 0) ? 24'h000000 : p_d2;
        nld++;
      end else m_sh = {m_sh[22:16], 1'b0, m_sh[14:8], 1'b0, m_sh[6:0], 1'b0};
      {p_d2, p_d1} = {p_d1, rd, gd, bd};
      lsc++; bkc++; fsc++;
      {p_lf, p_lb, p_ls, p_fs, p_col} = {lf, lb, ls, fs, ra[6:0]};
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  // main sequence: a whole frame, then a reset in mid-run
  initial begin
    void'($urandom(32'hA49521B5));
    repeat (5) @(posedge clk);
    #1 reset_chk();
    reset_n = 1'b1;
    @(posedge clk);
    #1 chk("first load", 1, lf);
    for (int i = 0; i < 30000 && frames == 0; i++) begin
      @(posedge clk);
      // memory contents change only while retrace shows
      #1 if (rt) key = 8'($urandom);
    end
    chk("frame seen", 1, frames > 0);
    repeat ($urandom % 2000) @(posedge clk);
    #1 reset_n = 1'b0;
    @(posedge clk);
    #1 reset_chk();
    reset_n = 1'b1;
    @(posedge clk);
    #1 chk("first load again", 1, lf);
    repeat (3000) @(posedge clk);
    close_out;
  end
endmodule
`default_nettype wire
